/* File: rtl/abf_exec.sv */
// Execution unit for add, add-carry, add-overflow, and, and branch-false.
// Assumes the fetch path holds an instruction until instr_ready is high,
// and that the byte memory answers a read in the cycle its request is shown.
//
// What this block does
// - Register add writes sum into destination, flag kept.
// - Immediate add sign-extends eight bits and adds to destination.
// - Add with carry adds flag in and loads carry out into flag.
// - Overflow add stores sum; flag set on signed overflow only.
// - Register and writes bitwise AND into destination, flag kept.
// - Immediate and on register zero zero-extends; upper 24 bits clear.
// - Byte mask: read base plus register zero, AND, write back; 3 cycles.
// - Branch-false branches when flag clear, else falls through.
// - Target offset is sign-extended displacement doubled.
// - Target base is branch address plus 4.
// - Taken branch takes three cycles, not taken one.
// - Branch-false in a delay slot raises illegal slot.
// - Unassigned codes outside a delay slot raise the invalid-instruction exception.
// - Invalid or PC-writing slot instruction raises slot exception.
`timescale 1ns/1ps
module abf_exec
    import abf_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire abf_pkg::abf_instr_s   instr,
    output logic                       instr_ready,
    output abf_pkg::abf_mem_s          mem,
    input  wire logic [7:0]            mem_rdata,
    output logic [31:0]                pc,
    output logic                       cond_flag,
    output logic                       exc_invalid,
    output logic                       exc_slot
);
    typedef struct packed {
        abf_state_e  state;
        logic [31:0] pc;
        logic        flag;
        logic [31:0] global_base;
        logic [3:0]  wait_cnt;
        logic [7:0]  mask;
        logic        ready;
        abf_mem_s    mem;
        logic        exc_inv;
        logic        exc_slot;
    } abf_state_s;

    abf_state_s  st_reg;
    abf_state_s  st_next;
    logic [31:0] gpr_reg [16];
    logic        gpr_we;
    logic [3:0]  gpr_wsel;
    logic [31:0] gpr_wdata;

    logic [3:0]  rd_sel;
    logic [3:0]  rs_sel;
    logic [31:0] rd_val;
    logic [31:0] rs_val;
    logic [32:0] sum33;
    logic [31:0] imm_sx;
    logic [31:0] disp_x2;
    logic        dec_rr;
    logic        is_add, is_add_cy, is_add_ov, is_and;
    logic        is_addi, is_andi, is_andm, is_brf;
    logic        take;
    logic        is_known;

    always_comb begin
        rd_sel  = instr.code[11:8];
        rs_sel  = instr.code[7:4];
        rd_val  = gpr_reg[rd_sel];
        rs_val  = gpr_reg[rs_sel];
        imm_sx  = {{24{instr.code[7]}}, instr.code[7:0]};
        disp_x2 = {imm_sx[30:0], 1'b0};
        dec_rr  = instr.code[15:12] == OP_HI_RR;
        is_add  = dec_rr && instr.code[3:0] == FN_ADD;
        is_add_cy = dec_rr && instr.code[3:0] == FN_ADD_CY;
        is_add_ov = dec_rr && instr.code[3:0] == FN_ADD_OV;
        is_and  = instr.code[15:12] == OP_HI_AND
                  && instr.code[3:0] == FN_AND;
        is_addi = instr.code[15:12] == OP_HI_ADDI;
        is_andi = instr.code[15:8] == OP_ANDI;
        is_andm = instr.code[15:8] == OP_ANDM;
        is_brf  = instr.code[15:8] == OP_BRF;
        is_known = is_add || is_addi || is_add_cy || is_add_ov || is_and
                   || is_andi || is_andm || is_brf;
        take    = is_brf && !st_reg.flag;
        // Carry in is zero except for add-with-carry; wraps at 32 bits
        sum33   = {1'b0, rd_val} + {1'b0, is_addi ? imm_sx : rs_val}
                  + {32'h0, is_add_cy & st_reg.flag};
    end

    always_comb begin
        st_next        = st_reg;
        st_next.exc_inv  = 1'b0;
        st_next.exc_slot = 1'b0;
        st_next.mem.rd_req = 1'b0;
        st_next.mem.wr_req = 1'b0;
        gpr_we    = 1'b0;
        gpr_wsel  = rd_sel;
        gpr_wdata = sum33[31:0];
        case (st_reg.state)
            ST_RUN: begin
                if (instr.valid && st_reg.ready) begin
                    st_next.pc = st_reg.pc + PC_STEP;
                    if (is_brf && instr.in_slot) begin
                        st_next.exc_slot = 1'b1;
                        st_next.pc = st_reg.pc;
                    end else if (is_add || is_addi) begin
                        gpr_we = 1'b1;
                    end else if (is_add_cy) begin
                        gpr_we = 1'b1;
                        st_next.flag = sum33[32];
                    end else if (is_add_ov) begin
                        gpr_we = 1'b1;
                        st_next.flag = (rd_val[31] == rs_val[31])
                            && (sum33[31] != rd_val[31]);
                    end else if (is_and) begin
                        gpr_we    = 1'b1;
                        gpr_wdata = rd_val & rs_val;
                    end else if (is_andi) begin
                        gpr_we    = 1'b1;
                        gpr_wsel  = 4'h0;
                        gpr_wdata = gpr_reg[0]
                            & {24'h0, instr.code[7:0]};
                    end else if (is_andm) begin
                        st_next.mem.addr = st_reg.global_base
                            + gpr_reg[0];
                        st_next.mem.rd_req = 1'b1;
                        st_next.mask  = instr.code[7:0];
                        st_next.ready = 1'b0;
                        st_next.state = ST_MRD;
                    end else if (take) begin
                        st_next.pc = st_reg.pc + PC_BASE_OFS
                            + disp_x2;
                        st_next.wait_cnt = TAKEN_WAIT;
                        st_next.ready = 1'b0;
                        st_next.state = ST_BWAIT;
                    end else if (!is_brf && instr.in_slot) begin
                        // Unknown code in a delay slot is a slot fault
                        st_next.exc_slot = 1'b1;
                        st_next.pc = st_reg.pc;
                    end else if (!is_brf) begin
                        st_next.exc_inv = 1'b1;
                        st_next.pc = st_reg.pc;
                    end
                end
            end
            ST_MRD: begin
                st_next.mem.wr_req = 1'b1;
                st_next.mem.wdata  = mem_rdata & st_reg.mask;
                st_next.state = ST_MWR;
            end
            ST_MWR: begin
                st_next.ready = 1'b1;
                st_next.state = ST_RUN;
            end
            ST_BWAIT: begin
                st_next.wait_cnt = st_reg.wait_cnt - 4'h1;
                // Two dead cycles after the accept edge, ready on the third
                if (st_reg.wait_cnt == 4'h1) begin
                    st_next.ready = 1'b1;
                    st_next.state = ST_RUN;
                end
            end
            default: st_next.state = ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '{state: ST_RUN, pc: RESET_PC, ready: 1'b1,
                        default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Register file written per entry; reset keeps it simple and known
    for (genvar g = 0; g < 16; g++) begin : g_gpr
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                gpr_reg[g] <= 32'h0;
            end else if (gpr_we && gpr_wsel == 4'(g)) begin
                gpr_reg[g] <= gpr_wdata;
            end
        end
    end

    assign instr_ready = st_reg.ready;
    assign mem         = st_reg.mem;
    assign pc          = st_reg.pc;
    assign cond_flag   = st_reg.flag;
    assign exc_invalid = st_reg.exc_inv;
    assign exc_slot    = st_reg.exc_slot;

    sequence s_refill;
        !instr_ready [*2] ##1 instr_ready;
    endsequence

    sequence s_mask_tail;
        mem.wr_req ##1 instr_ready;
    endsequence

    property p_taken_three;
        @(posedge sys_clk) disable iff (rst)
        (st_reg.state == ST_RUN && st_reg.ready && instr.valid && take
         && !instr.in_slot) |=> s_refill;
    endproperty
    a_taken_three: assert property (p_taken_three)
        else $error("taken branch not three cycles");

    property p_andm_len;
        @(posedge sys_clk) disable iff (rst)
        $rose(mem.rd_req) |=> s_mask_tail;
    endproperty
    a_andm_len: assert property (p_andm_len)
        else $error("byte mask not three cycles");

    property p_slot;
        @(posedge sys_clk) disable iff (rst)
        (st_reg.state == ST_RUN && st_reg.ready && instr.valid && is_brf
         && instr.in_slot) |=> exc_slot && $stable(pc);
    endproperty
    a_slot: assert property (p_slot)
        else $error("slot branch not refused");

    property p_not_taken;
        @(posedge sys_clk) disable iff (rst)
        (st_reg.state == ST_RUN && st_reg.ready && instr.valid && is_brf
         && st_reg.flag && !instr.in_slot)
        |=> pc == $past(pc) + PC_STEP && instr_ready;
    endproperty
    a_not_taken: assert property (p_not_taken)
        else $error("untaken branch wrong");

    property p_invalid;
        @(posedge sys_clk) disable iff (rst)
        (st_reg.state == ST_RUN && st_reg.ready && instr.valid && !is_known
         && !instr.in_slot) |=> exc_invalid && !exc_slot && $stable(pc);
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("unassigned code not refused");

    property p_slot_invalid;
        @(posedge sys_clk) disable iff (rst)
        (st_reg.state == ST_RUN && st_reg.ready && instr.valid && !is_known
         && instr.in_slot) |=> exc_slot && !exc_invalid && $stable(pc);
    endproperty
    a_slot_invalid: assert property (p_slot_invalid)
        else $error("unknown slot code not refused");

    property p_flag_kept;
        @(posedge sys_clk) disable iff (rst)
        (st_reg.state == ST_RUN && st_reg.ready && instr.valid
         && (is_add || is_addi || is_and || is_andi)) |=> $stable(cond_flag);
    endproperty
    a_flag_kept: assert property (p_flag_kept)
        else $error("flag changed by plain add or and");
endmodule

/* File: rtl/abf_pkg.sv */
// Package for the add/and/branch-false execution block.
// Assumes a single core clock; shared by the execution unit and its bench.
package abf_pkg;
    localparam int         XLEN         = 32;
    localparam logic [31:0] RESET_PC    = 32'h0000_0000;
    localparam logic [31:0] PC_STEP     = 32'h0000_0002;
    localparam logic [31:0] PC_BASE_OFS = 32'h0000_0004;
    localparam logic [3:0]  TAKEN_WAIT  = 4'h2;
    // Opcode patterns: top nibble alone (immediate add), top nibble and low nibble, or top byte
    localparam logic [3:0]  OP_HI_RR    = 4'h3;
    localparam logic [3:0]  OP_HI_AND   = 4'h2;
    localparam logic [3:0]  OP_HI_ADDI  = 4'h7;
    localparam logic [3:0]  FN_ADD      = 4'hc;
    localparam logic [3:0]  FN_ADD_CY   = 4'he;
    localparam logic [3:0]  FN_ADD_OV   = 4'hf;
    localparam logic [3:0]  FN_AND      = 4'h9;
    localparam logic [7:0]  OP_ANDI     = 8'hc9;
    localparam logic [7:0]  OP_ANDM     = 8'hcd;
    localparam logic [7:0]  OP_BRF      = 8'h8b;

    typedef struct packed {
        logic        valid;
        logic [15:0] code;
        logic        in_slot;
    } abf_instr_s;

    typedef struct packed {
        logic        rd_req;
        logic        wr_req;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } abf_mem_s;

    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_MRD   = 4'b0010,
        ST_MWR   = 4'b0100,
        ST_BWAIT = 4'b1000
    } abf_state_e;
endpackage

/* File: dv/abf_mem_model.sv */
// Byte data memory standing on the far side of the execution unit's port.
// Assumes one request at a time. A read answers in its request cycle and
// holds one more; after that the bus shows the inverse, so stale use shows.
`timescale 1ns/1ps
module abf_mem_model
    import abf_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire abf_pkg::abf_mem_s mem,
    output logic [7:0]             mem_rdata,
    output logic [31:0]            last_addr,
    output logic [7:0]             last_data,
    output logic [31:0]            wr_cnt
);
    logic [7:0] store [256];
    logic [7:0] held = 8'h00;
    logic       held_v = 1'b0;

    initial begin
        for (int i = 0; i < 256; i++) store[i] = 8'(i) ^ 8'h5a;
        last_addr = '0;
        last_data = '0;
        wr_cnt = '0;
    end

    always @(posedge sys_clk) begin
        held_v <= (mem.rd_req === 1'b1);
        if (mem.rd_req === 1'b1) held <= store[mem.addr[7:0]];
        if (mem.wr_req === 1'b1) begin
            store[mem.addr[7:0]] <= mem.wdata;
            last_addr <= mem.addr;
            last_data <= mem.wdata;
            wr_cnt <= wr_cnt + 32'h1;
        end
    end

    assign mem_rdata = (mem.rd_req === 1'b1) ? store[mem.addr[7:0]] :
                       held_v ? held : ~held;
endmodule

/* File: dv/add_and_branch_false_exec_test.sv */
// Self-checking bench for abf_exec; a reference model tracks registers,
// flag and pc. Registers are read back through the byte-mask address,
// since that is the only path by which they leave the block.
`timescale 1ns/1ps
module add_and_branch_false_exec_test;
    import abf_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    abf_instr_s  instr = '0;
    abf_mem_s    mem;
    logic        instr_ready, cond_flag, exc_invalid, exc_slot, fl;
    logic [7:0]  mem_rdata, last_data, im;
    logic [3:0]  n, m;
    logic [31:0] pc, last_addr, wr_cnt, epc;
    logic [31:0] r [16];
    logic [7:0]  bm [256];
    int          mismatches = 0;
    int          checks_done = 0;

    initial forever #2 sys_clk = ~sys_clk;

    abf_exec u_dut (.sys_clk(sys_clk), .rst(rst), .instr(instr),
        .instr_ready(instr_ready), .mem(mem), .mem_rdata(mem_rdata),
        .pc(pc), .cond_flag(cond_flag), .exc_invalid(exc_invalid),
        .exc_slot(exc_slot));
    abf_mem_model u_mem (.sys_clk(sys_clk), .mem(mem),
        .mem_rdata(mem_rdata), .last_addr(last_addr),
        .last_data(last_data), .wr_cnt(wr_cnt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [31:0] brf_target(input logic [31:0] p,
                                               input logic [7:0]  d);
        return p + 32'h4 + {{23{d[7]}}, d, 1'b0};
    endfunction

    task automatic wait_rdy(output int c);
        c = 1;
        while (instr_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            c++;
            if (c > 50) begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask

    task automatic step(input logic [15:0] c, input logic slot);
        logic [32:0] s;
        logic [31:0] a, b, nxt, w0;
        logic [3:0]  dn;
        int          ecyc, cyc;
        logic        einv, eslot;
        dn = c[11:8];
        a = r[dn];
        b = r[c[7:4]];
        nxt = epc + 32'h2;
        ecyc = 1;
        einv = 1'b0;
        eslot = 1'b0;
        w0 = wr_cnt;
        if (c[15:12] == 4'h3 && c[3:0] == 4'hc) r[dn] = a + b;
        else if (c[15:12] == 4'h7) r[dn] = a + {{24{c[7]}}, c[7:0]};
        else if (c[15:12] == 4'h3 && c[3:0] == 4'he) begin
            s = {1'b0, a} + {1'b0, b} + 33'(fl);
            r[dn] = s[31:0];
            fl = s[32];
        end else if (c[15:12] == 4'h3 && c[3:0] == 4'hf) begin
            r[dn] = a + b;
            fl = (a[31] == b[31]) && (r[dn][31] != a[31]);
        end else if (c[15:12] == 4'h2 && c[3:0] == 4'h9) begin
            r[dn] = a & b;
        end else if (c[15:8] == 8'hc9) r[0] = r[0] & {24'h0, c[7:0]};
        else if (c[15:8] == 8'hcd) begin
            bm[r[0][7:0]] = bm[r[0][7:0]] & c[7:0];
            ecyc = 3;
        end else if (c[15:8] == 8'h8b) begin
            if (slot) begin
                eslot = 1'b1;
                nxt = epc;
            end else if (!fl) begin
                nxt = brf_target(epc, c[7:0]);
                ecyc = 3;
            end
        end else begin
            einv = !slot;
            eslot = slot;
            nxt = epc;
        end
        wait_rdy(cyc);
        instr = '{valid: 1'b1, code: c, in_slot: slot};
        @(posedge sys_clk);
        #1;
        if (ecyc > 1) instr.valid = 1'b0;
        check(exc_invalid, einv);
        check(exc_slot, eslot);
        wait_rdy(cyc);
        epc = nxt;
        check(32'(cyc), 32'(ecyc));
        check(pc, epc);
        check(cond_flag, fl);
        if (c[15:8] == 8'hcd) begin
            check(last_addr, r[0]);
            check(last_data, bm[r[0][7:0]]);
            check(wr_cnt - w0, 32'h1);
        end
    endtask

    task automatic peek(input logic [3:0] k, input logic [7:0] v);
        step(16'hc900, 1'b0);
        step({8'h30, k, 4'hc}, 1'b0);
        step({8'hcd, v}, 1'b0);
    endtask

    initial begin
        void'($urandom(32'hde7c));
        for (int i = 0; i < 256; i++) bm[i] = 8'(i) ^ 8'h5a;
        for (int i = 0; i < 16; i++) r[i] = '0;
        fl = 1'b0;
        epc = '0;
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check(pc, 32'h0);
        check(cond_flag, 1'b0);
        // Walk a one up to the sign bit, then overflow and carry corners
        step(16'h7101, 1'b0);
        repeat (31) step(16'h311c, 1'b0);
        step(16'h71ff, 1'b0);
        step(16'h7201, 1'b0);
        step(16'h312f, 1'b0);
        step(16'h8b10, 1'b0);
        step(16'h312e, 1'b1);
        step(16'h8b80, 1'b1);
        step(16'hffff, 1'b0);
        step(16'hffff, 1'b1);
        step(16'h300f, 1'b0);
        step(16'h8b7f, 1'b0);
        step(16'h8b80, 1'b0);
        peek(4'h1, 8'h80);
        repeat (400) begin
            n = 4'($urandom);
            m = 4'($urandom);
            im = 8'($urandom);
            case ($urandom_range(9, 0))
                0: step({4'h3, n, m, 4'hc}, 1'($urandom));
                1: step({4'h7, n, im}, 1'($urandom));
                2: step({4'h3, n, m, 4'he}, 1'($urandom));
                3: step({4'h3, n, m, 4'hf}, 1'($urandom));
                4: step({4'h2, n, m, 4'h9}, 1'($urandom));
                5: step({8'hc9, im}, 1'($urandom));
                6: step({8'hcd, im}, 1'($urandom));
                7: step({8'h8b, im}, 1'($urandom));
                8: step(16'hffff, 1'($urandom));
                default: peek(n, im);
            endcase
        end
        step(16'hcd0f, 1'b0);
        report_and_stop();
    end
endmodule
